// file: pwp_apb_master.sv
// apb master model for the protect bank
`timescale 1ns/100ps
`default_nettype none
module pwp_apb_master import pwp_pkg::*; (
	input wire logic CLK_SYS,
	output logic PSEL,
	output logic PENABLE,
	output logic PWRITE,
	output logic [ADDR_W-1:0] PADDR,
	output logic [DATA_W-1:0] PWDATA,
	output logic [STRB_W-1:0] PSTRB,
	input wire logic [DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
	end
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
		output logic [DATA_W-1:0] rd, output logic er);
		@(posedge CLK_SYS) #1;
		{PSEL, PWRITE, PADDR, PWDATA, PSTRB} = {1'b1, w, a, d, s};
		@(posedge CLK_SYS) #1;
		PENABLE = 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		#1;
		{PSEL, PENABLE} = 2'b00;
		// released data no longer shows the last value
		PWDATA = ~d;
	endtask : xfer
endmodule : pwp_apb_master
`default_nettype wire

// file: pwp_peripheral_write_protect.sv
// peripheral write-protect register bank with bus slave and write guard
`timescale 1ns/100ps
`default_nettype none
module pwp_peripheral_write_protect #(
	parameter logic [pwp_pkg::DATA_W-1:0] IMPL_MASK = pwp_pkg::SYS_INST_MASK,
	parameter logic [pwp_pkg::DATA_W-1:0] RESET_VAL = pwp_pkg::SYS_INST_RESET
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [pwp_pkg::ADDR_W-1:0] PADDR,
	input wire logic [pwp_pkg::DATA_W-1:0] PWDATA,
	input wire logic [pwp_pkg::STRB_W-1:0] PSTRB,
	output var logic [pwp_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output var logic [pwp_pkg::DATA_W-1:0] LOCK_STATE,
	input wire logic [pwp_pkg::DATA_W-1:0] PERIPH_WR,
	output logic [pwp_pkg::DATA_W-1:0] PERIPH_WR_DENY
);
	import pwp_pkg::*;

	// refuse maps the register logic cannot serve
	if (DATA_W % 8 != 0) begin : g_bad_width
		$error("data width is not whole bytes");
	end
	if (IMPL_MASK == '0) begin : g_no_bits
		$error("no protection bit implemented");
	end
	if ((RESET_VAL & ~IMPL_MASK) != '0) begin : g_bad_reset
		$error("reset value sets unimplemented bits");
	end

	// expand byte strobes to a bit mask
	function automatic logic [DATA_W-1:0] lane_mask(
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < STRB_W; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : lane_mask

	logic [DATA_W-1:0] lock_r;
	logic [DATA_W-1:0] lock_nxt;
	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;
	logic access;
	logic setup;
	logic hit_set;
	logic hit_clr;
	logic mapped;
	logic [DATA_W-1:0] wmask;
	pwp_wr_type wr;

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	assign hit_set = (PADDR == OFS_LOCK_SET);
	assign hit_clr = (PADDR == OFS_LOCK_CLEAR);
	assign mapped = hit_set || hit_clr;
	// only addressed lanes and implemented bits take part
	assign wmask = lane_mask(PSTRB) & IMPL_MASK;

	always_comb begin
		wr.set_bits = '0;
		wr.clr_bits = '0;
		if (PWRITE && hit_set)
			wr.set_bits = PWDATA & wmask;
		if (PWRITE && hit_clr)
			wr.clr_bits = PWDATA & wmask;
		// lock of a locked, or unlock of an unlocked, peripheral
		wr.redundant = ((wr.set_bits & lock_r) != '0) ||
			((wr.clr_bits & ~lock_r) != '0);
	end

	assign PREADY = 1'b1;
	assign PSLVERR = access && (!mapped || (PWRITE && wr.redundant));

	always_comb begin
		lock_nxt = lock_r;
		// whole write applied in one edge, or dropped on error
		if (access && PWRITE && mapped && !wr.redundant) begin
			lock_nxt = (lock_r | wr.set_bits) & ~wr.clr_bits;
		end
		prdata_nxt = prdata_r;
		if (setup) begin
			prdata_nxt = '0;
			// both offsets read the same shared state
			if (!PWRITE && mapped)
				prdata_nxt = lock_r & IMPL_MASK & lane_mask(PSTRB);
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			lock_r <= RESET_VAL;
			prdata_r <= '0;
		end else begin
			lock_r <= lock_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign PRDATA = prdata_r;
	assign LOCK_STATE = lock_r;
	// writes to a locked peripheral are refused
	assign PERIPH_WR_DENY = PERIPH_WR & lock_r;

	// all checks run on the bus clock, off during reset
	default clocking cb_sys @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	sequence s_good_write;
		access && PWRITE && mapped && !wr.redundant;
	endsequence

	sequence s_bad_write;
		access && PWRITE && (!mapped || wr.redundant);
	endsequence

	sequence s_read_setup;
		setup && !PWRITE && mapped;
	endsequence

	a_set_locks: assert property (
		s_good_write and hit_set |=> ((lock_r & $past(wr.set_bits))
			== $past(wr.set_bits)))
		else $error("set write did not lock");

	a_clear_unlocks: assert property (
		s_good_write and hit_clr |=> ((lock_r & $past(wr.clr_bits)) == '0))
		else $error("clear write did not unlock");

	a_zero_keeps: assert property (
		s_good_write |=> ((lock_r & ~$past(PWDATA)) ==
			($past(lock_r) & ~$past(PWDATA))))
		else $error("zero bit changed protection");

	a_lane_only: assert property (
		access && PWRITE |=> ((lock_r & ~$past(wmask)) ==
			($past(lock_r) & ~$past(wmask))))
		else $error("unaddressed lane changed");

	a_redundant_err: assert property (
		access && PWRITE && hit_set && ((PWDATA & wmask & lock_r) != '0)
		|-> PSLVERR ##1 $stable(lock_r))
		else $error("double lock not refused");

	a_error_discard: assert property (
		s_bad_write |-> PSLVERR ##1 $stable(lock_r))
		else $error("refused write changed state");

	a_read_mirror: assert property (
		setup && !PWRITE && mapped ##1 access && !PWRITE && mapped
		|-> PRDATA == (lock_r & IMPL_MASK & lane_mask(PSTRB)))
		else $error("read data differs from lock state");

	a_reserved_zero: assert property (
		(lock_r & ~IMPL_MASK) == '0)
		else $error("reserved bit set");

	a_deny_locked: assert property (
		(PERIPH_WR & lock_r) != '0 |-> (PERIPH_WR_DENY != '0)
		##1 !$changed(lock_r) || $past(access && PWRITE))
		else $error("write to locked peripheral not refused");

	a_one_cycle: assert property (
		access |-> PREADY)
		else $error("access not completed in one cycle");

	// bus-side error and read checks
	a_clear_redundant: assert property (
		access && PWRITE && hit_clr && ((PWDATA & wmask & ~lock_r) != '0)
		|-> PSLVERR ##1 $stable(lock_r))
		else $error("double unlock not refused");

	a_zero_write: assert property (
		access && PWRITE && mapped && ((PWDATA & wmask) == '0)
		|-> !PSLVERR ##1 $stable(lock_r))
		else $error("all-zero write changed protection");

	a_good_quiet: assert property (
		s_good_write |-> !PSLVERR)
		else $error("accepted write flagged as error");

	a_err_in_access: assert property (
		!access |-> !PSLVERR)
		else $error("error outside access phase");

	a_read_keeps: assert property (
		access && !PWRITE |=> $stable(lock_r))
		else $error("read changed protection");

	a_read_lanes: assert property (
		s_read_setup ##1 access |-> (PRDATA & ~lane_mask(PSTRB)) == '0)
		else $error("unstrobed lane read nonzero");

	a_unmapped_read: assert property (
		setup && !PWRITE && !mapped |=> PRDATA == '0)
		else $error("unmapped read nonzero");

	// write-guard check
	a_deny_unlocked: assert property (
		(PERIPH_WR_DENY & ~lock_r) == '0)
		else $error("unlocked peripheral write refused");
endmodule : pwp_peripheral_write_protect
`default_nettype wire

// file: pwp_pkg.sv
// package: peripheral write-protect constants and types
`default_nettype none
package pwp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_LOCK_CLEAR = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LOCK_SET = 8'h04;
	// system controller instance: bit positions
	localparam int POS_DEBUG_UNIT_LOCK = 1;
	localparam int POS_FLASH_CONTROLLER_LOCK = 2;
	localparam int POS_IO_PORT_LOCK = 3;
	localparam int POS_TRACE_BUFFER_LOCK = 6;
	localparam logic [DATA_W-1:0] SYS_INST_MASK = 32'h0000_004E;
	localparam logic [DATA_W-1:0] SYS_INST_RESET = 32'h0000_0002;
	// peripheral-bus controller instance: bit fields
	localparam int POS_EVENT_ROUTER_LOCK = 1;
	localparam int POS_SERIAL_UNIT_LOCKS_LO = 2;
	localparam int POS_SERIAL_UNIT_LOCKS_HI = 7;
	localparam int POS_TIMER_INSTANCE_LOCKS_LO = 8;
	localparam int POS_TIMER_INSTANCE_LOCKS_HI = 15;
	localparam logic [DATA_W-1:0] PBUS_INST_MASK = 32'h0000_FFFE;
	localparam logic [DATA_W-1:0] PBUS_INST_RESET = 32'h0000_0000;
	// decoded effect of one bus write
	typedef struct packed {
		logic [DATA_W-1:0] set_bits;
		logic [DATA_W-1:0] clr_bits;
		logic redundant;
	} pwp_wr_type;
endpackage : pwp_pkg
`default_nettype wire

// file: tb_pwp_peripheral_write_protect.sv
// self-checking bench for the write-protect bank
`timescale 1ns/100ps
`default_nettype none
module tb_pwp_peripheral_write_protect;
	import pwp_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel, pen, pwr, prdy, perr, er;
	logic sel2 = 1'b0;
	logic prdy1, perr1, prdy2, perr2;
	logic [DATA_W-1:0] prd1, prd2, lock2, deny2;
	logic [ADDR_W-1:0] pa;
	logic [STRB_W-1:0] ps;
	logic [DATA_W-1:0] pwd, prd, lock, deny, rd;
	logic [DATA_W-1:0] pwrq = '0;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	pwp_peripheral_write_protect DUT (.CLK_SYS(clk), .RST_B(rst_b),
		.PSEL(psel && !sel2), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PSTRB(ps), .PRDATA(prd1), .PREADY(prdy1),
		.PSLVERR(perr1), .LOCK_STATE(lock), .PERIPH_WR(pwrq),
		.PERIPH_WR_DENY(deny));
	pwp_peripheral_write_protect #(.IMPL_MASK(PBUS_INST_MASK),
		.RESET_VAL(PBUS_INST_RESET)) DUT2 (.CLK_SYS(clk),
		.RST_B(rst_b), .PSEL(psel && sel2), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(ps),
		.PRDATA(prd2), .PREADY(prdy2), .PSLVERR(perr2),
		.LOCK_STATE(lock2), .PERIPH_WR(pwrq), .PERIPH_WR_DENY(deny2));
	assign prd = sel2 ? prd2 : prd1;
	assign prdy = sel2 ? prdy2 : prdy1;
	assign perr = sel2 ? perr2 : perr1;
	pwp_apb_master u_mst (.CLK_SYS(clk), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(ps),
		.PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [STRB_W-1:0] s, input logic ee);
		u_mst.xfer(1'b1, a, d, s, rd, er);
		chk("pslverr", {31'b0, ee}, {31'b0, er});
	endtask : wr
	task automatic look(input logic [DATA_W-1:0] e);
		u_mst.xfer(1'b0, OFS_LOCK_CLEAR, '0, 4'hF, rd, er);
		chk("clear reg", e, rd);
		u_mst.xfer(1'b0, OFS_LOCK_SET, '0, 4'hF, rd, er);
		chk("set reg", e, rd);
		chk("lock state", e, sel2 ? lock2 : lock);
	endtask : look
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		look(SYS_INST_RESET);
		wr(OFS_LOCK_SET, 32'h0000_004C, 4'hF, 1'b0);
		look(32'h0000_004E);
		wr(OFS_LOCK_SET, 32'h0000_0002, 4'h1, 1'b1);
		wr(OFS_LOCK_CLEAR, 32'h0000_0004, 4'h1, 1'b0);
		wr(OFS_LOCK_CLEAR, 32'h0000_0000, 4'hF, 1'b0);
		wr(OFS_LOCK_CLEAR, 32'h0000_000C, 4'h1, 1'b1);
		look(32'h0000_004A);
		wr(OFS_LOCK_SET, 32'hFFFF_FF00, 4'hE, 1'b0);
		wr(OFS_LOCK_CLEAR, 32'h0000_0040, 4'h2, 1'b0);
		wr(8'h08, 32'h0000_0040, 4'hF, 1'b1);
		look(32'h0000_004A);
		u_mst.xfer(1'b0, OFS_LOCK_SET, '0, 4'hE, rd, er);
		chk("sparse read", 32'h0000_0000, rd);
		u_mst.xfer(1'b0, 8'h08, '0, 4'hF, rd, er);
		chk("unmapped read", 32'h0000_0000, rd);
		chk("unmapped err", 32'h0000_0001, {31'b0, er});
		sel2 = 1'b1;
		look(PBUS_INST_RESET);
		wr(OFS_LOCK_SET, 32'hFFFF_FFFF, 4'hF, 1'b0);
		look(32'h0000_FFFE);
		wr(OFS_LOCK_CLEAR, 32'h0000_FF00, 4'h2, 1'b0);
		look(32'h0000_00FE);
		wr(OFS_LOCK_SET, 32'h0000_0100, 4'h2, 1'b0);
		wr(OFS_LOCK_CLEAR, 32'h0000_0002, 4'h1, 1'b0);
		look(32'h0000_01FC);
		@(posedge clk) #1 pwrq = '1;
		#10 chk("deny", 32'h0000_004A, deny);
		chk("deny pbus", 32'h0000_01FC, deny2);
		@(posedge clk) #1 pwrq = 32'h0000_0004;
		#10 chk("deny", 32'h0000_0000, deny);
		chk("deny pbus", 32'h0000_0004, deny2);
		@(posedge clk) #1 rst_b = 1'b0;
		@(posedge clk) #1 rst_b = 1'b1;
		sel2 = 1'b0;
		look(SYS_INST_RESET);
		sel2 = 1'b1;
		look(PBUS_INST_RESET);
		tally_and_finish();
	end
endmodule : tb_pwp_peripheral_write_protect
`default_nettype wire
